/* rtl/sssr_top.sv */
// Supply supervisor: reset, power-fail, early warning and watchdog
`include "sssr_consts.svh"
`default_nettype none
module sssr_top
#(
    parameter int unsigned RST_HOLD_CYC  = `SSSR_RST_HOLD_CYC,
    parameter int unsigned WDOG_CYC      = `SSSR_WDOG_CYC,
    parameter int unsigned DEBOUNCE_CYC  = `SSSR_DEBOUNCE_CYC,
    parameter int unsigned IRQ_PULSE_CYC = `SSSR_IRQ_PULSE_CYC,
    parameter int unsigned SAMPLE_CYC    = `SSSR_SAMPLE_CYC
)
(
    input  wire logic      clk,
    input  wire logic      reset_n,
    input  wire logic      supply_ok,
    input  wire logic      early_warn_ok,
    input  wire logic      wdog_kick_n,
    input  wire logic      button_reset_n,
    input  wire logic      reset_mode_sel,
    input  wire logic      wake_sleep_ctl,
    input  wire logic      sram_enable_req,
    output logic           reset_out_n,
    output logic           reset_out,
    output logic           power_fail,
    output logic           power_fail_n,
    output logic           early_warning_irq_n,
    output logic           sram_enable_out,
    output logic           sleep_mode
);
    import sssr_pkg::*;

    localparam int HOLD_W = $clog2(RST_HOLD_CYC + 1);
    localparam int WD_W   = $clog2(WDOG_CYC + 1);
    localparam int DEB_W  = $clog2(DEBOUNCE_CYC + 1);
    localparam int IRQ_W  = $clog2(IRQ_PULSE_CYC + 1);
    localparam int SMP_W  = $clog2(SAMPLE_CYC + 1);

    // Synchronised pins
    logic [`SSSR_PIN_COUNT-1:0] pin_raw;
    logic [`SSSR_PIN_COUNT-1:0] pin_s;
    logic            supply_ok_s;     // Supply in tolerance
    logic            ew_low_s;        // Sense point below threshold
    logic            kick_n_s;        // Watchdog strobe
    logic            button_n_s;      // Raw button level
    logic            mode_cmos_s;     // High selects CMOS behaviour
    logic            wake_s;          // Low requests sleep
    logic            sram_req_s;      // Memory enable request

    // Event detection
    logic            supply_prev_q;   // Last supply level
    logic            kick_prev_q;     // Last strobe level
    logic            pwr_seen_q;      // Supply has been good once
    logic            supply_rise;
    logic            supply_fall;
    logic            kick_edge;

    // Reset controller
    sssr_rst_state_e state_q;
    sssr_rst_state_e state_d;
    logic            hold_load;       // Restart the timed hold
    logic [HOLD_W-1:0] hold_cnt_q;    // Remaining hold cycles
    logic            fault_rst;       // Supply fault that resets
    logic            btn_en;          // Button allowed to act

    // Watchdog
    logic [WD_W-1:0] wd_cnt_q;        // Cycles since last kick
    logic            wd_run;
    logic            wd_expire;

    // Button debounce
    logic [DEB_W-1:0] deb_cnt_q;      // Stability counter
    logic            btn_held_q;      // Debounced press

    // Early warning
    logic [SMP_W-1:0] smp_cnt_q;      // Sample interval counter
    logic [1:0]      low_cnt_q;       // Consecutive low samples
    logic            smp_tick;
    logic            ew_trip;
    logic            irq_start;
    logic [IRQ_W-1:0] irq_cnt_q;      // Remaining pulse cycles

    // Every pin crosses two flops before use
    assign pin_raw[`SSSR_PIN_SUPPLY] = supply_ok;
    assign pin_raw[`SSSR_PIN_EW]     = early_warn_ok;
    assign pin_raw[`SSSR_PIN_KICK]   = wdog_kick_n;
    assign pin_raw[`SSSR_PIN_BUTTON] = button_reset_n;
    assign pin_raw[`SSSR_PIN_MODE]   = reset_mode_sel;
    assign pin_raw[`SSSR_PIN_WAKE]   = wake_sleep_ctl;
    assign pin_raw[`SSSR_PIN_SRAM]   = sram_enable_req;

    sssr_sync
    #(
        .WIDTH     (`SSSR_PIN_COUNT),
        .RESET_VAL (`SSSR_PIN_RST)
    )
    u_sync
    (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (pin_raw),
        .sync_out (pin_s)
    );

    assign supply_ok_s = pin_s[`SSSR_PIN_SUPPLY];
    assign ew_low_s    = !pin_s[`SSSR_PIN_EW];
    assign kick_n_s    = pin_s[`SSSR_PIN_KICK];
    assign button_n_s  = pin_s[`SSSR_PIN_BUTTON];
    assign mode_cmos_s = pin_s[`SSSR_PIN_MODE];
    assign wake_s      = pin_s[`SSSR_PIN_WAKE];
    assign sram_req_s  = pin_s[`SSSR_PIN_SRAM];

    // Edge history for supply and strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            supply_prev_q <= 1'b0;
            kick_prev_q   <= 1'b1;
            pwr_seen_q    <= 1'b0;
        end
        else
        begin
            supply_prev_q <= supply_ok_s;
            kick_prev_q   <= kick_n_s;
            if (supply_ok_s)
                pwr_seen_q <= 1'b1;
        end
    end

    assign supply_rise = supply_ok_s && !supply_prev_q;
    assign supply_fall = !supply_ok_s && supply_prev_q;
    assign kick_edge   = !kick_n_s && kick_prev_q;

    // NMOS resets through the whole outage; CMOS only before first power
    assign fault_rst = !supply_ok_s &&
                       (!mode_cmos_s || !pwr_seen_q);

    // Button is ignored on low sense in CMOS mode or with supply bad
    assign btn_en = supply_ok_s && !(mode_cmos_s && ew_low_s);

    // Next state: fault beats button beats timers
    always_comb
    begin
        state_d   = state_q;
        hold_load = 1'b0;
        if (fault_rst)
            state_d = SSSR_FAULT;
        else if (btn_held_q && btn_en)
            state_d = SSSR_BTN;
        else if (supply_rise)
        begin
            // Supply return gives a fresh power-on hold unless an enabled button press takes priority
            state_d   = SSSR_HOLD;
            hold_load = 1'b1;
        end
        else
        begin
            unique case (state_q)
                SSSR_FAULT:
                begin
                    state_d   = SSSR_HOLD;
                    hold_load = 1'b1;
                end
                SSSR_BTN:
                begin
                    // Hold counts from the release
                    state_d   = SSSR_HOLD;
                    hold_load = 1'b1;
                end
                SSSR_HOLD:
                begin
                    if (hold_cnt_q <= HOLD_W'(1))
                        state_d = SSSR_RUN;
                end
                SSSR_RUN:
                begin
                    if (wd_expire)
                    begin
                        state_d   = SSSR_HOLD;
                        hold_load = 1'b1;
                    end
                end
            endcase
        end
    end

    // Controller state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= SSSR_FAULT;
        else
            state_q <= state_d;
    end

    // Hold timer; every source loads the full hold, so a reload never
    // shortens what is still pending
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hold_cnt_q <= '0;
        else if (hold_load)
            hold_cnt_q <= HOLD_W'(RST_HOLD_CYC);
        else if (hold_cnt_q != '0)
            hold_cnt_q <= hold_cnt_q - HOLD_W'(1);
    end

    // Watchdog stops and clears in sleep, with supply bad, or on low sense in CMOS
    assign wd_run    = (state_q == SSSR_RUN) && supply_ok_s && wake_s &&
                       !(mode_cmos_s && ew_low_s);
    assign wd_expire = wd_run && !kick_edge &&
                       (wd_cnt_q == WD_W'(WDOG_CYC - 1));

    // Watchdog counter, started at reset release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wd_cnt_q <= '0;
        else if (!wd_run || kick_edge || wd_expire)
            wd_cnt_q <= '0;
        else
            wd_cnt_q <= wd_cnt_q + WD_W'(1);
    end

    // Button debounce: level must differ for the full window to flip
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            deb_cnt_q  <= '0;
            btn_held_q <= 1'b0;
        end
        else if (btn_held_q == !button_n_s)
            deb_cnt_q <= '0;
        else if (deb_cnt_q == DEB_W'(DEBOUNCE_CYC - 1))
        begin
            deb_cnt_q  <= '0;
            btn_held_q <= !button_n_s;
        end
        else
            deb_cnt_q <= deb_cnt_q + DEB_W'(1);
    end

    // Sense sampling interval
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            smp_cnt_q <= '0;
        else if (smp_tick)
            smp_cnt_q <= '0;
        else
            smp_cnt_q <= smp_cnt_q + SMP_W'(1);
    end

    assign smp_tick = (smp_cnt_q == SMP_W'(SAMPLE_CYC - 1));

    // Low-sample run; saturates so one crossing fires once
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            low_cnt_q <= '0;
        else if (smp_tick)
        begin
            if (!ew_low_s)
                low_cnt_q <= '0;
            else if (low_cnt_q != 2'(`SSSR_EW_SAMPLES))
                low_cnt_q <= low_cnt_q + 2'h1;
        end
    end

    // Fire on the third low sample; blocked until the supply is up
    assign ew_trip   = smp_tick && ew_low_s && supply_ok_s &&
                       (low_cnt_q == 2'(`SSSR_EW_SAMPLES - 1));
    assign irq_start = ew_trip ||
                       (mode_cmos_s && pwr_seen_q && supply_fall);

    // Pulse timer; removal is by timeout only, so the least width holds
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_cnt_q <= '0;
        else if (irq_start)
            irq_cnt_q <= IRQ_W'(IRQ_PULSE_CYC);
        else if (irq_cnt_q != '0)
            irq_cnt_q <= irq_cnt_q - IRQ_W'(1);
    end

    // Registered outputs, reset state shows reset and power-fail active
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reset_out_n         <= 1'b0;
            reset_out           <= 1'b1;
            power_fail          <= 1'b1;
            power_fail_n        <= 1'b0;
            early_warning_irq_n <= 1'b1;
            sram_enable_out     <= 1'b0;
            sleep_mode          <= 1'b0;
        end
        else
        begin
            reset_out_n  <= (state_d == SSSR_RUN);
            reset_out    <= (state_d != SSSR_RUN);
            power_fail   <= !supply_ok_s;
            power_fail_n <= supply_ok_s;
            early_warning_irq_n <= !(irq_start ||
                                     irq_cnt_q > IRQ_W'(1));
            sram_enable_out <= sram_req_s && supply_ok_s;
            sleep_mode   <= !wake_s;
        end
    end

    // Helper counters for the width checks below
    logic [HOLD_W-1:0] act_cnt_q;   // Cycles reset has been active
    logic [IRQ_W-1:0]  irq_low_q;   // Cycles warning has been low

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            act_cnt_q <= '0;
            irq_low_q <= '0;
        end
        else
        begin
            if (reset_out_n)
                act_cnt_q <= '0;
            else if (act_cnt_q != HOLD_W'(RST_HOLD_CYC))
                act_cnt_q <= act_cnt_q + HOLD_W'(1);
            if (early_warning_irq_n)
                irq_low_q <= '0;
            else if (irq_low_q != IRQ_W'(IRQ_PULSE_CYC))
                irq_low_q <= irq_low_q + IRQ_W'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_fault_resets;
        (!supply_ok_s && !mode_cmos_s) |=> (!reset_out_n && power_fail);
    endproperty
    a_fault_resets: assert property (p_fault_resets)
        else $error("supply fault did not force reset");

    property p_rst_complement;
        reset_out_n != reset_out;
    endproperty
    a_rst_complement: assert property (p_rst_complement)
        else $error("reset outputs not opposite");

    property p_pf_complement;
        power_fail != power_fail_n;
    endproperty
    a_pf_complement: assert property (p_pf_complement)
        else $error("power-fail outputs not opposite");

    property p_hold_width;
        $rose(reset_out_n) |-> act_cnt_q >= HOLD_W'(RST_HOLD_CYC);
    endproperty
    a_hold_width: assert property (p_hold_width)
        else $error("reset released before hold time");

    // Count resumes only if the watchdog ran in the cycle after the edge
    property p_kick_restart;
        (kick_edge && wd_run) |=> (wd_cnt_q == '0) ##1
                                  ($past(wd_run) -> wd_cnt_q == WD_W'(1));
    endproperty
    a_kick_restart: assert property (p_kick_restart)
        else $error("strobe edge did not restart watchdog");

    property p_wd_timeout;
        wd_expire && !fault_rst && !supply_rise && !btn_held_q
            |=> !reset_out_n ##1 !reset_out_n;
    endproperty
    a_wd_timeout: assert property (p_wd_timeout)
        else $error("watchdog expiry did not reset");

    property p_cmos_no_down_reset;
        (mode_cmos_s && pwr_seen_q && state_q == SSSR_RUN && supply_fall
            && !btn_held_q && !wd_expire) |=> reset_out_n;
    endproperty
    a_cmos_no_down_reset: assert property (p_cmos_no_down_reset)
        else $error("reset asserted on CMOS power-down");

    property p_cmos_irq;
        (mode_cmos_s && pwr_seen_q && supply_fall) |=>
            !early_warning_irq_n;
    endproperty
    a_cmos_irq: assert property (p_cmos_irq)
        else $error("no warning pulse on CMOS power fail");

    property p_button_reset;
        (btn_held_q && btn_en) |=> !reset_out_n;
    endproperty
    a_button_reset: assert property (p_button_reset)
        else $error("button press did not reset");

    property p_irq_width;
        $rose(early_warning_irq_n) |->
            irq_low_q >= IRQ_W'(IRQ_PULSE_CYC);
    endproperty
    a_irq_width: assert property (p_irq_width)
        else $error("warning pulse too short");

    property p_ew_trip;
        ew_trip |=> !early_warning_irq_n;
    endproperty
    a_ew_trip: assert property (p_ew_trip)
        else $error("threshold crossing gave no warning");

    property p_sram_block;
        !supply_ok_s |=> !sram_enable_out;
    endproperty
    a_sram_block: assert property (p_sram_block)
        else $error("memory enabled with supply bad");

    c_wd_expire: cover property (wd_expire);
    c_button:    cover property ($fell(btn_held_q));
    c_irq:       cover property ($rose(early_warning_irq_n));
    c_cmos_fail: cover property (mode_cmos_s && supply_fall);

endmodule // sssr_top
`default_nettype wire

/* common/sssr_consts.svh */
// Constants for the supply supervisor: pin order, reset values, timing
`ifndef SSSR_CONSTS_SVH
`define SSSR_CONSTS_SVH

// Clock rate in kHz (50 MHz)
`define SSSR_CLK_KHZ       50000

// Times in their own units
`define SSSR_RST_HOLD_MS   25
`define SSSR_WDOG_MS       400
`define SSSR_DEBOUNCE_MS   10
`define SSSR_SAMPLE_US     33
`define SSSR_IRQ_PULSE_US  200

// Derived cycle counts (least times round up)
`define SSSR_RST_HOLD_CYC  (`SSSR_RST_HOLD_MS * `SSSR_CLK_KHZ)
`define SSSR_WDOG_CYC      (`SSSR_WDOG_MS * `SSSR_CLK_KHZ)
`define SSSR_DEBOUNCE_CYC  (`SSSR_DEBOUNCE_MS * `SSSR_CLK_KHZ)
`define SSSR_SAMPLE_CYC    ((`SSSR_SAMPLE_US * `SSSR_CLK_KHZ) / 1000)
`define SSSR_IRQ_PULSE_CYC \
    ((`SSSR_IRQ_PULSE_US * `SSSR_CLK_KHZ + 999) / 1000)

// Consecutive low samples needed before the early warning fires
`define SSSR_EW_SAMPLES    3

// Synchroniser bit positions
`define SSSR_PIN_SUPPLY    0
`define SSSR_PIN_EW        1
`define SSSR_PIN_KICK      2
`define SSSR_PIN_BUTTON    3
`define SSSR_PIN_MODE      4
`define SSSR_PIN_WAKE      5
`define SSSR_PIN_SRAM      6
`define SSSR_PIN_COUNT     7

// Synchroniser reset value: supply bad, sense high, strobes idle, awake
`define SSSR_PIN_RST       7'h2e

`endif

/* common/sssr_pkg.sv */
// Types for the supply supervisor
`default_nettype none
package sssr_pkg;

    // Reset controller states, one-hot
    typedef enum logic [3:0] {
        SSSR_RUN   = 4'b0001,  // Reset released
        SSSR_FAULT = 4'b0010,  // Supply fault holds reset
        SSSR_BTN   = 4'b0100,  // Button held down
        SSSR_HOLD  = 4'b1000   // Timed hold before release
    } sssr_rst_state_e;

endpackage
`default_nettype wire

/* rtl/sssr_sync.sv */
// Two-flop synchroniser bank for asynchronous pin inputs
`default_nettype none
module sssr_sync
#(
    parameter int unsigned          WIDTH     = 1,
    parameter logic [WIDTH-1:0]     RESET_VAL = '0
)
(
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [WIDTH-1:0]   async_in,
    output logic      [WIDTH-1:0]   sync_out
);

    logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage

    // Both stages reset to the idle level of each pin
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // sssr_sync
`default_nettype wire

/* dv/sssr_host_model.sv */
// Host processor model: strobes the watchdog, counts early warnings
`default_nettype none
module sssr_host_model
#(
    parameter int unsigned KICK_CYC = 60  // Kept under a quarter period
)
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic kick_en,             // Software still alive
    input  wire logic reset_out_n,         // Host halted while low
    input  wire logic early_warning_irq_n,
    output logic      wdog_kick_n,
    output int        irq_count            // Early warnings taken
);
    timeunit 1ns;
    timeprecision 1ps;

    int   gap_q;  // Cycles since the last strobe
    logic irq_q;  // Interrupt level one cycle ago

    // Strobe only while running; low for two cycles so the sync sees it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap_q       <= 0;
            wdog_kick_n <= 1'b1;
        end
        else if (!reset_out_n || !kick_en)
        begin
            gap_q       <= 0;
            wdog_kick_n <= 1'b1;
        end
        else
        begin
            gap_q       <= (gap_q >= KICK_CYC) ? 0 : gap_q + 1;
            wdog_kick_n <= !(gap_q >= KICK_CYC - 1);
        end
    end

    // Falling interrupt edges are counted as one warning each
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_q     <= 1'b1;
            irq_count <= 0;
        end
        else
        begin
            irq_q <= early_warning_irq_n;
            if (irq_q && !early_warning_irq_n)
                irq_count <= irq_count + 1;
        end
    end
endmodule // sssr_host_model
`default_nettype wire

/* dv/tb_supply_supervisor_reset.sv */
// Self-checking bench for the supply supervisor
`default_nettype none
module tb_supply_supervisor_reset;
    timeunit 1ns;
    timeprecision 1ps;
    import sssr_pkg::*;

    // Short counts keep the run brief
    localparam int HOLD = 50;
    localparam int WDOG = 400;
    localparam int DEB  = 10;
    localparam int PUL  = 20;
    localparam int SMP  = 8;

    logic clk      = 1'b0;
    logic reset_n  = 1'b0;
    logic sup_ok   = 1'b0;  // Supply comparator
    logic ew_ok    = 1'b1;  // Sense comparator
    logic btn_n    = 1'b1;
    logic mode     = 1'b0;  // Start in NMOS
    logic wake     = 1'b1;
    logic sram_req = 1'b0;
    logic kick_en  = 1'b1;
    logic kick_n, rst_n_o, rst_o, pf, pf_n, irq_n, sram_o, sleep;
    int   irq_count;
    int   fails    = 0;
    int   compares = 0;
    int   n;

    // 50 MHz clock
    always #10 clk = ~clk;

    sssr_top #(.RST_HOLD_CYC(HOLD), .WDOG_CYC(WDOG), .DEBOUNCE_CYC(DEB),
        .IRQ_PULSE_CYC(PUL), .SAMPLE_CYC(SMP)) i_dut (
        .clk(clk), .reset_n(reset_n), .supply_ok(sup_ok),
        .early_warn_ok(ew_ok), .wdog_kick_n(kick_n),
        .button_reset_n(btn_n), .reset_mode_sel(mode),
        .wake_sleep_ctl(wake), .sram_enable_req(sram_req),
        .reset_out_n(rst_n_o), .reset_out(rst_o), .power_fail(pf),
        .power_fail_n(pf_n), .early_warning_irq_n(irq_n),
        .sram_enable_out(sram_o), .sleep_mode(sleep));

    sssr_host_model i_host (
        .clk(clk), .reset_n(reset_n), .kick_en(kick_en),
        .reset_out_n(rst_n_o), .early_warning_irq_n(irq_n),
        .wdog_kick_n(kick_n), .irq_count(irq_count));

    // Verdict and end of run
    task automatic results();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One comparison, four-state exact
    task automatic check(input logic seen, input logic exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t: saw %b, wanted %b", $time, seen, exp);
        end
    endtask

    // Both reset pins against one expected activity
    task automatic check_rst(input logic act);
        check(rst_o, act);
        check(rst_n_o, !act);
    endtask

    // Expected memory enable: request gated by a good supply
    function automatic logic exp_sram(input logic req, input logic ok);
        return req && ok;
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Bounded wait on reset (0) or interrupt (1); k counts cycles
    task automatic wait_on(input int w, input logic lvl, input int bnd,
                           output int k);
        k = 0;
        while (((w == 0) ? rst_n_o : irq_n) !== lvl && k < bnd)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= bnd)
        begin
            fails++;
            $display("BAD %0t: wait ran out", $time);
            results();
        end
    endtask

    initial
    begin
        void'($urandom(32'h7ac9));
        // Power-up with the supply still bad
        cyc(5);
        @(posedge clk);
        reset_n <= 1'b1;
        cyc(10);
        check_rst(1'b1);
        check(pf, 1'b1);
        check(pf_n, 1'b0);
        check(sram_o, 1'b0);
        @(posedge clk);
        sup_ok   <= 1'b1;
        sram_req <= 1'b1;
        cyc(HOLD);
        check_rst(1'b1);
        wait_on(0, 1'b1, 20, n);
        check(pf_n, 1'b1);
        check(sram_o, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            sram_req <= 1'($urandom);
            cyc(4);
            check(sram_o, exp_sram(sram_req, sup_ok));
        end
        $display("Test power-up done");

        // Kicked watchdog stays quiet, then starved
        n = 0;
        repeat (3 * WDOG)
        begin
            @(negedge clk);
            n += (rst_o !== 1'b0);
        end
        check(n == 0, 1'b1);
        @(posedge clk);
        kick_en <= 1'b0;
        wait_on(0, 1'b0, WDOG + 80, n);
        check(n > WDOG - 70, 1'b1);
        @(posedge clk);
        kick_en <= 1'b1;
        wait_on(0, 1'b1, HOLD + 20, n);
        check(n >= HOLD, 1'b1);
        $display("Test watchdog done");

        // Button: short glitch ignored, real press resets
        @(posedge clk);
        btn_n <= 1'b0;
        cyc(1 + $urandom % (DEB - 4));
        @(posedge clk);
        btn_n <= 1'b1;
        n = 0;
        repeat (30)
        begin
            @(negedge clk);
            n += (rst_o !== 1'b0);
        end
        check(n == 0, 1'b1);
        @(posedge clk);
        btn_n <= 1'b0;
        wait_on(0, 1'b0, DEB + 10, n);
        cyc(5 + $urandom % 20);
        check_rst(1'b1);
        @(posedge clk);
        btn_n <= 1'b1;
        wait_on(0, 1'b1, HOLD + DEB + 20, n);
        check(n >= HOLD, 1'b1);
        $display("Test button done");

        // Early warning: two samples too few, a long dip pulses
        @(posedge clk);
        ew_ok <= 1'b0;
        cyc(2 * SMP - 1);
        @(posedge clk);
        ew_ok <= 1'b1;
        cyc(40);
        check(irq_n, 1'b1);
        check(irq_count == 0, 1'b1);
        @(posedge clk);
        ew_ok <= 1'b0;
        wait_on(1, 1'b0, 5 * SMP, n);
        // Third low sample lands two to three intervals in, plus sync
        check(n >= 2 * SMP + 4 && n <= 3 * SMP + 3, 1'b1);
        wait_on(1, 1'b1, PUL + 10, n);
        check(n == PUL, 1'b1);
        @(posedge clk);
        ew_ok <= 1'b1;
        $display("Test early warning done");

        // NMOS supply loss holds reset throughout
        @(posedge clk);
        sup_ok <= 1'b0;
        wait_on(0, 1'b0, 6, n);
        check(sram_o, 1'b0);
        n = 0;
        repeat (300)
        begin
            @(negedge clk);
            n += (rst_o !== 1'b1);
        end
        check(n == 0, 1'b1);
        @(posedge clk);
        sup_ok <= 1'b1;
        wait_on(0, 1'b1, HOLD + 20, n);
        check(n >= HOLD, 1'b1);
        $display("Test NMOS loss done");

        // CMOS supply loss: warning pulse, no reset until return
        @(posedge clk);
        mode <= 1'b1;
        cyc(5);
        @(posedge clk);
        sup_ok <= 1'b0;
        n = 0;
        repeat (30)
        begin
            @(negedge clk);
            n += (rst_o !== 1'b0);
        end
        check(n == 0, 1'b1);
        check(irq_count == 2, 1'b1);
        check(pf, 1'b1);
        @(posedge clk);
        sup_ok <= 1'b1;
        wait_on(0, 1'b0, 6, n);
        wait_on(0, 1'b1, HOLD + 20, n);
        check(n >= HOLD, 1'b1);
        $display("Test CMOS loss done");

        // Sleep control follows the wake input
        @(posedge clk);
        wake <= 1'b0;
        cyc(4);
        check(sleep, 1'b1);
        @(posedge clk);
        wake <= 1'b1;
        cyc(4);
        check(sleep, 1'b0);
        $display("Test sleep done");
        results();
    end
endmodule // tb_supply_supervisor_reset
`default_nettype wire
